// file: shared/sac_pkg.sv
// Purpose: shared constants and types for the converter pin link
// Assumes: one 40 MHz clock per end
// Notes:   times in ns, cycle counts derived from them
package sac_pkg;
  localparam int NB       = 14;
  localparam int CLK_MHZ  = 40;
  // host acquisition gap after busy rises
  localparam int ACQ_NS   = 1000;
  localparam int ACQ_CYC  = (ACQ_NS * CLK_MHZ + 999) / 1000;
  // host wait after leaving shutdown
  localparam int WAKE_NS  = 500;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  // chip select ahead of start or shutdown edge
  localparam int CSSU_NS  = 40;
  localparam int CSSU_CYC = (CSSU_NS * CLK_MHZ + 999) / 1000;
  // start low hold, well inside the 2100 ns window
  localparam int CVLO_NS  = 200;
  localparam int CVLO_CYC = (CVLO_NS * CLK_MHZ + 999) / 1000;
  // internal conversion clock period
  localparam int ICLK_NS  = 200;
  localparam int ICLK_CYC = (ICLK_NS * CLK_MHZ) / 1000;
  localparam int DIVW     = 4;
  // host made external conversion clock, half period
  localparam int ECLK_NS  = 250;
  localparam int ECLK_CYC = (ECLK_NS * CLK_MHZ) / 1000;
  // host shift clock, half period
  localparam int SCLK_NS  = 200;
  localparam int SCLK_CYC = (SCLK_NS * CLK_MHZ) / 1000;
  // host parallel read wait
  localparam int RDW_NS   = 150;
  localparam int RDW_CYC  = (RDW_NS * CLK_MHZ + 999) / 1000;
  localparam int CNTW     = 8;
  // low data lines reused in serial mode
  localparam int D_ECK    = 4;
  localparam int D_SCK    = 3;
  localparam int D_CKO    = 2;
  localparam int D_DOUT   = 1;
  localparam int D_CSEL   = 0;
  // device input sync vector positions
  localparam int P_CS  = 0;
  localparam int P_RD  = 1;
  localparam int P_CV  = 2;
  localparam int P_PD  = 3;
  localparam int P_SER = 4;
  localparam int P_SEL = 5;
  localparam int P_ECK = 6;
  localparam int P_SCK = 7;
  localparam int NP    = 8;
  typedef enum logic [2:0] {
    SD_IDLE = 3'b001,
    SD_CONV = 3'b010,
    SD_DOWN = 3'b100
  } sac_dst_t;
  typedef enum logic [6:0] {
    SH_IDLE  = 7'b0000001,
    SH_CVLO  = 7'b0000010,
    SH_WLO   = 7'b0000100,
    SH_WHI   = 7'b0001000,
    SH_READ  = 7'b0010000,
    SH_SHIFT = 7'b0100000,
    SH_DOWN  = 7'b1000000
  } sac_hst_t;
endpackage : sac_pkg

// file: shared/sac_if.sv
// Purpose: pins between converter and host
// Assumes: data lines have a weak pull-up
// Notes:   each end drives a line while its enable is low
`timescale 1ns/1ps
interface sac_if;
  logic        cs_n;
  logic        rd_n;
  logic        convert_start_n;
  logic        power_down_n;
  logic        output_format_select;
  logic        busy_n;
  logic [13:0] dev_d;
  logic [13:0] dev_oe_n;
  logic [13:0] hst_d;
  logic [13:0] hst_oe_n;
  logic [13:0] d;
  // device wins, then host, else pulled high
  assign d = (~dev_oe_n & dev_d) | (dev_oe_n & ~hst_oe_n & hst_d)
           | (dev_oe_n & hst_oe_n);
  modport dev (
    input  cs_n, rd_n, convert_start_n, power_down_n,
    input  output_format_select, d,
    output busy_n, dev_d, dev_oe_n
  );
  modport host (
    output cs_n, rd_n, convert_start_n, power_down_n,
    output output_format_select, hst_d, hst_oe_n,
    input  busy_n, d
  );
endinterface : sac_if

// file: verilog/sac_dev.sv
// Purpose: converter control end: start, status, approximation, output
// Assumes: sample_code is the ideal offset-binary code of the input
// Notes:   all pins pass two flops; one extra stage finds edges
//
// How it works
// - start falling edge begins a conversion
// - start and read need chip select low
// - power down low enters nap or sleep
// - parallel drivers on only with read, select
// - busy low throughout every conversion
// - start edges ignored while converting
// - approximation register cleared at conversion start
// - fourteen decisions, most significant first
// - final result copied to output latch
// - parallel bus, top line carries msb
// - format select reuses five low lines
// - clock select low internal, high external, honoured in serial mode only
// - host waits acquisition time before start
// - host releases start early or after busy
// - unipolar binary, bipolar two's complement
// - host waits wake time after nap
`timescale 1ns/1ps
module sac_dev
  import sac_pkg::*;
(
  // pins
  sac_if.dev          pins,
  // clock and reset
  input  wire logic   clk,
  input  wire logic   arst_n,
  // analog side
  input  wire logic [NB-1:0] sample_code,
  input  wire logic   bipolar,
  // status
  output logic [NB-1:0] result,
  output logic        converting,
  output logic        napping,
  output logic        sleeping
);

  typedef struct packed {
    sac_dst_t        st;
    logic [NP-1:0]   s1;
    logic [NP-1:0]   s2;
    logic [NP-1:0]   s3;
    logic [NB-1:0]   appr;
    logic [3:0]      idx;
    logic [NB-1:0]   lat;
    logic [NB-1:0]   shr;
    logic [DIVW-1:0] div;
    logic            cclk;
    logic            nap;
    logic            slp;
    logic [NB-1:0]   dq;
    logic [NB-1:0]   oen;
  } sac_dstate_t;

  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(ICLK_CYC - 1);
  localparam logic [DIVW-1:0] DIV_HALF = DIVW'(ICLK_CYC / 2);
  localparam logic [3:0]      IDX_TOP  = 4'(NB - 1);
  localparam logic [NB-1:0]   MSB_MASK = NB'(1) << (NB - 1);

  sac_dstate_t r;
  sac_dstate_t n;
  logic [NP-1:0] pin_in;
  logic [NB-1:0] trial;
  logic [NB-1:0] dec;
  logic          tick;
  logic          itick;
  logic          cs_lo;
  logic          ser;

  // edge seen between the second and third stage
  function automatic logic fell(input logic [NP-1:0] prv,
                                input logic [NP-1:0] cur,
                                input int i);
    fell = prv[i] & ~cur[i];
  endfunction : fell

  function automatic logic rose(input logic [NP-1:0] prv,
                                input logic [NP-1:0] cur,
                                input int i);
    rose = ~prv[i] & cur[i];
  endfunction : rose

  always_comb begin
    pin_in         = '0;
    pin_in[P_CS]   = pins.cs_n;
    pin_in[P_RD]   = pins.rd_n;
    pin_in[P_CV]   = pins.convert_start_n;
    pin_in[P_PD]   = pins.power_down_n;
    pin_in[P_SER]  = pins.output_format_select;
    pin_in[P_SEL]  = pins.d[D_CSEL];
    pin_in[P_ECK]  = pins.d[D_ECK];
    pin_in[P_SCK]  = pins.d[D_SCK];
  end

  always_comb begin
    n      = r;
    n.s1   = pin_in;
    n.s2   = r.s1;
    n.s3   = r.s2;
    cs_lo  = ~r.s2[P_CS];
    ser    = r.s2[P_SER];
    // internal conversion clock runs free; cheap and keeps conv_clock_out steady
    itick  = (r.div == DIV_LAST);
    n.div  = itick ? '0 : r.div + 1'b1;
    n.cclk = (r.div < DIV_HALF);
    // external clock only honoured in serial mode
    tick   = (ser & r.s2[P_SEL]) ? rose(r.s3, r.s2, P_ECK)
                                 : itick;
    trial  = r.appr | (MSB_MASK >> (IDX_TOP - r.idx));
    dec    = (trial <= sample_code) ? trial : r.appr;
    // serial shift on shift clock falling edge
    if (ser && fell(r.s3, r.s2, P_SCK)) begin
      n.shr = {r.shr[NB-2:0], 1'b0};
    end
    case (r.st)
      SD_IDLE: begin
        if (fell(r.s3, r.s2, P_PD)) begin
          n.st  = SD_DOWN;
          n.nap = cs_lo;
          n.slp = ~cs_lo;
        end else if (cs_lo && fell(r.s3, r.s2, P_CV)) begin
          n.st  = SD_CONV;
          n.appr = '0;
          n.idx = IDX_TOP;
        end
      end
      SD_CONV: begin
        // start edges are not looked at here: no restart
        if (tick) begin
          n.appr = dec;
          n.idx = r.idx - 1'b1;
          if (r.idx == 4'h0) begin
            // bipolar flips the msb of offset binary
            n.lat = dec ^ (bipolar ? MSB_MASK : '0);
            n.shr = dec ^ (bipolar ? MSB_MASK : '0);
            n.st  = SD_IDLE;
          end
        end
      end
      SD_DOWN: begin
        // host owns the wake wait
        if (rose(r.s3, r.s2, P_PD)) begin
          n.st  = SD_IDLE;
          n.nap = 1'b0;
          n.slp = 1'b0;
        end
      end
      default: begin
        n.st = SD_IDLE;
      end
    endcase
    // pin drive, registered so lines change one cycle after state
    if (ser) begin
      n.dq          = '0;
      n.oen         = '1;
      n.dq[D_CKO]   = r.cclk;
      n.dq[D_DOUT]  = r.shr[NB-1];
      n.oen[D_CKO]  = 1'b0;
      n.oen[D_DOUT] = 1'b0;
    end else begin
      n.dq  = r.lat;
      n.oen = (cs_lo && !r.s2[P_RD]) ? '0 : '1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r      <= '0;
      r.st   <= SD_IDLE;
      r.s1   <= '1;
      r.s2   <= '1;
      r.s3   <= '1;
      r.oen  <= '1;
    end else begin
      r <= n;
    end
  end

  assign pins.busy_n   = (r.st != SD_CONV);
  assign pins.dev_d    = r.dq;
  assign pins.dev_oe_n = r.oen;
  assign result        = r.lat;
  assign converting    = (r.st == SD_CONV);
  assign napping       = r.nap;
  assign sleeping      = r.slp;

endmodule : sac_dev

// file: verilog/sac_host.sv
// Purpose: host end: starts conversions and reads results
// Assumes: device end on the same pins
// Notes:   busy and data lines pass two flops before use
`timescale 1ns/1ps
module sac_host
  import sac_pkg::*;
(
  // pins
  sac_if.host         pins,
  // clock and reset
  input  wire logic   clk,
  input  wire logic   arst_n,
  // request side
  input  wire logic   start,
  input  wire logic   serial_mode,
  input  wire logic   ext_clock,
  input  wire logic   shutdown_req,
  input  wire logic   shutdown_deep,
  output logic        ready,
  // answer side
  output logic [NB-1:0] result,
  output logic        result_valid
);

  typedef struct packed {
    sac_hst_t        st;
    logic            b1;
    logic            b2;
    logic [NB-1:0]   d1;
    logic [NB-1:0]   d2;
    logic [CNTW-1:0] cnt;
    logic [CNTW-1:0] gap;
    logic [CNTW-1:0] ecnt;
    logic [3:0]      nbit;
    logic [NB-1:0]   shv;
    logic [NB-1:0]   res;
    logic            vld;
    logic            cs_n;
    logic            rd_n;
    logic            cv_n;
    logic            pd_n;
    logic            ser;
    logic            ext;
    logic            sck;
    logic            eck;
  } sac_hstate_t;

  sac_hstate_t r;
  sac_hstate_t n;

  always_comb begin
    n     = r;
    n.b1  = pins.busy_n;
    n.b2  = r.b1;
    n.d1  = pins.d;
    n.d2  = r.d1;
    n.vld = 1'b0;
    if (r.gap != '0) begin
      n.gap = r.gap - 1'b1;
    end
    // external conversion clock runs free; its line is driven only in serial mode
    if (r.ecnt == CNTW'(ECLK_CYC - 1)) begin
      n.ecnt = '0;
      n.eck  = ~r.eck;
    end else begin
      n.ecnt = r.ecnt + 1'b1;
    end
    case (r.st)
      SH_IDLE: begin
        if (shutdown_req) begin
          n.cs_n = shutdown_deep;
          n.cnt  = '0;
          n.st   = SH_DOWN;
        end else if (start && r.gap == '0) begin
          n.ser  = serial_mode;
          n.ext  = ext_clock;
          n.cs_n = 1'b0;
          n.cnt  = '0;
          n.st   = SH_CVLO;
        end
      end
      SH_CVLO: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == CNTW'(CSSU_CYC)) begin
          n.cv_n = 1'b0;
        end
        // short low hold keeps the release early
        if (r.cnt == CNTW'(CSSU_CYC + CVLO_CYC)) begin
          n.cv_n = 1'b1;
          n.st   = SH_WLO;
        end
      end
      SH_WLO: begin
        if (!r.b2) begin
          n.st = SH_WHI;
        end
      end
      SH_WHI: begin
        if (r.b2) begin
          n.gap  = CNTW'(ACQ_CYC);
          n.cnt  = '0;
          n.nbit = '0;
          if (r.ser) begin
            n.sck = 1'b1;
            n.st  = SH_SHIFT;
          end else begin
            n.rd_n = 1'b0;
            n.st   = SH_READ;
          end
        end
      end
      SH_READ: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == CNTW'(RDW_CYC + 2)) begin
          n.res  = r.d2;
          n.vld  = 1'b1;
          n.rd_n = 1'b1;
          n.cs_n = 1'b1;
          n.st   = SH_IDLE;
        end
      end
      SH_SHIFT: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == CNTW'(SCLK_CYC - 1)) begin
          n.cnt = '0;
          if (r.sck) begin
            // sample just before the falling edge
            n.shv  = {r.shv[NB-2:0], r.d2[D_DOUT]};
            n.sck  = 1'b0;
            n.nbit = r.nbit + 1'b1;
            if (r.nbit == 4'(NB - 1)) begin
              n.res  = {r.shv[NB-2:0], r.d2[D_DOUT]};
              n.vld  = 1'b1;
              n.sck  = 1'b1;
              n.cs_n = 1'b1;
              n.st   = SH_IDLE;
            end
          end else begin
            n.sck = 1'b1;
          end
        end
      end
      SH_DOWN: begin
        if (r.cnt != CNTW'(CSSU_CYC)) begin
          n.cnt = r.cnt + 1'b1;
        end else if (r.pd_n) begin
          n.pd_n = 1'b0;
        end else if (!shutdown_req) begin
          n.pd_n = 1'b1;
          n.cs_n = 1'b1;
          n.gap  = CNTW'(WAKE_CYC);
          n.st   = SH_IDLE;
        end
      end
      default: begin
        n.st = SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r      <= '0;
      r.st   <= SH_IDLE;
      r.b1   <= 1'b1;
      r.b2   <= 1'b1;
      r.cs_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.cv_n <= 1'b1;
      r.pd_n <= 1'b1;
      r.sck  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign ready  = (r.st == SH_IDLE) && r.gap == '0 && !shutdown_req;
  assign result = r.res;
  assign result_valid = r.vld;
  assign pins.cs_n = r.cs_n;
  assign pins.rd_n = r.rd_n;
  assign pins.convert_start_n = r.cv_n;
  assign pins.power_down_n = r.pd_n;
  assign pins.output_format_select = r.ser;
  always_comb begin
    pins.hst_d            = '1;
    pins.hst_oe_n         = '1;
    pins.hst_d[D_ECK]     = r.eck;
    pins.hst_d[D_SCK]     = r.sck;
    pins.hst_d[D_CSEL]    = r.ext;
    pins.hst_oe_n[D_ECK]  = ~r.ser;
    pins.hst_oe_n[D_SCK]  = ~r.ser;
    pins.hst_oe_n[D_CSEL] = ~r.ser;
  end

endmodule : sac_host

// file: sim/sac_checker.sv
// Purpose: pin checks on the converter link
// Assumes: device end sees pins through two flops and an edge stage
// Notes:   lengths are counted in helper logic, not by repetition
`timescale 1ns/1ps
module sac_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // link
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        convert_start_n,
  input wire logic        power_down_n,
  input wire logic        output_format_select,
  input wire logic        busy_n,
  input wire logic [13:0] dev_d,
  input wire logic [13:0] dev_oe_n,
  input wire logic [13:0] d
);
  logic [8:0] lo_cnt_r;
  // saturates so a stuck busy cannot wrap into the legal window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) lo_cnt_r <= 9'h000;
    else if (busy_n) lo_cnt_r <= 9'h000;
    else if (lo_cnt_r != 9'h1ff) lo_cnt_r <= lo_cnt_r + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_start_busy:
    assert property ($fell(convert_start_n) && !cs_n && busy_n
      && power_down_n |-> ##[2:6] !busy_n) else $error("no busy");
  a_busy_cause:
    assert property ($fell(busy_n) |-> !convert_start_n && !cs_n)
      else $error("busy without start");
  a_conv_len:
    assert property ($rose(busy_n) && !(output_format_select && d[0])
      |-> lo_cnt_r inside {[9'h064:9'h078]}) else $error("conv length");
  a_read_on:
    assert property (!rd_n && !cs_n && !output_format_select
      && !$past(rd_n, 3) && !$past(cs_n, 3)
      && !$past(output_format_select, 3) |-> dev_oe_n == 14'h0000)
      else $error("read not driven");
  a_read_cause:
    assert property (dev_oe_n[13:5] != 9'h1ff |-> !$past(rd_n, 3)
      && !$past(cs_n, 3) && !$past(output_format_select, 3))
      else $error("drive without read");
  a_all_lines:
    assert property (dev_oe_n[13:5] != 9'h1ff |-> dev_oe_n == 14'h0000)
      else $error("partial bus");
  a_serial_lines:
    assert property (output_format_select
      && $past(output_format_select, 4) |-> dev_oe_n[13:5] == 9'h1ff
      && dev_oe_n[2:1] == 2'b00) else $error("serial lines");
  // the reload at conversion end moves the data line with the clock idle
  a_shift_edge:
    assert property (output_format_select
      && $past(output_format_select, 6) && busy_n && $past(busy_n, 2)
      && $changed(dev_d[1]) |-> !d[3]) else $error("shift edge");
endmodule : sac_checker

// file: sim/sar_adc_control_interface_tb_top.sv
// Purpose: end to end bench, host end against converter end
// Assumes: host end keeps setup, start width and acquisition gap
// Notes:   a second converter end is driven by hand for refusals
`timescale 1ns/1ps
module sar_adc_control_interface_tb_top;
  import sac_pkg::*;
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  logic          start = 1'b0;
  logic          serial_mode = 1'b0;
  logic          ext_clock = 1'b0;
  logic          shutdown_req = 1'b0;
  logic          shutdown_deep = 1'b0;
  logic          bipolar = 1'b0;
  logic [NB-1:0] sample_code = 14'h0000;
  logic [NB-1:0] h_result, d_result, d2_result;
  logic [NB-1:0] prev = 14'h0000;
  logic          ready, result_valid, converting, napping, sleeping;
  logic          busy_q = 1'b1;
  logic          cv_q = 1'b1;
  logic          pd_q = 1'b1;
  logic [NB-1:0] codes [4] = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555};
  int            n_fail = 0;
  int            checks_done = 0;
  int            lo = 0, len = 0, gap = 1000, cv_lo = 0, wake = 1000;
  int            waited;
  sac_if pins ();
  sac_if pins2 ();
  always #12.5 clk = ~clk;
  sac_dev u_sac_dev (.pins(pins.dev), .clk(clk), .arst_n(arst_n),
    .sample_code(sample_code), .bipolar(bipolar), .result(d_result),
    .converting(converting), .napping(napping), .sleeping(sleeping));
  sac_host u_sac_host (.pins(pins.host), .clk(clk), .arst_n(arst_n),
    .start(start), .serial_mode(serial_mode), .ext_clock(ext_clock),
    .shutdown_req(shutdown_req), .shutdown_deep(shutdown_deep),
    .ready(ready), .result(h_result), .result_valid(result_valid));
  sac_dev u_sac_dev_2 (.pins(pins2.dev), .clk(clk), .arst_n(arst_n),
    .sample_code(14'h1234), .bipolar(1'b0), .result(d2_result),
    .converting(), .napping(), .sleeping());
  sac_checker u_sac_checker (.clk(clk), .arst_n(arst_n),
    .cs_n(pins.cs_n), .rd_n(pins.rd_n),
    .convert_start_n(pins.convert_start_n),
    .power_down_n(pins.power_down_n),
    .output_format_select(pins.output_format_select),
    .busy_n(pins.busy_n), .dev_d(pins.dev_d), .dev_oe_n(pins.dev_oe_n),
    .d(pins.d));
  task automatic cmp(input string what, input logic [NB-1:0] exp,
                     input logic [NB-1:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  function automatic logic probe(input int sel);
    case (sel)
      0: return ready;
      1: return pins.busy_n;
      2: return result_valid;
      3: return napping;
      4: return sleeping;
      default: return pins2.busy_n;
    endcase
  endfunction : probe
  task automatic wait_on(input int sel, input logic lvl, input string what);
    waited = 0;
    while (probe(sel) !== lvl && waited < 2000) begin
      @(negedge clk);
      waited++;
    end
    if (probe(sel) !== lvl) begin
      cmp(what, 14'(lvl), 14'(probe(sel)));
      final_report();
    end
  endtask : wait_on
  // host timing seen on the wire
  always @(posedge clk) begin
    if (arst_n) begin
      busy_q <= pins.busy_n;
      cv_q <= pins.convert_start_n;
      pd_q <= pins.power_down_n;
      lo <= pins.busy_n ? 0 : lo + 1;
      gap <= (pins.busy_n && !busy_q) ? 0 : gap + 1;
      wake <= (pins.power_down_n && !pd_q) ? 0 : wake + 1;
      cv_lo <= pins.convert_start_n ? 0 : cv_lo + 1;
      if (pins.busy_n && !busy_q) len <= lo;
      if (!pins.convert_start_n && cv_q) begin
        cmp("acq gap", 14'h1, 14'(gap >= ACQ_CYC));
        cmp("wake gap", 14'h1, 14'(wake >= WAKE_CYC));
      end
      if (pins.convert_start_n && !cv_q)
        cmp("start low", 14'h1, 14'(cv_lo <= 84));
    end
  end
  task automatic convert(input logic ser, input logic ext, input logic bip,
                         input logic [NB-1:0] code);
    logic [NB-1:0] exp;
    exp = bip ? code ^ 14'h2000 : code;
    wait_on(0, 1'b1, "ready");
    serial_mode = ser;
    ext_clock = ext;
    bipolar = bip;
    sample_code = code;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_on(1, 1'b0, "busy low");
    cmp("old latch", prev, d_result);
    cmp("converting", 14'h1, 14'(converting));
    wait_on(1, 1'b1, "busy high");
    @(negedge clk);
    cmp("new latch", exp, d_result);
    cmp("ext clock", 14'(ser && ext), 14'(len > 150));
    wait_on(2, 1'b1, "valid");
    cmp("host word", exp, h_result);
    prev = exp;
  endtask : convert
  initial begin
    pins2.cs_n = 1'b1;
    pins2.rd_n = 1'b1;
    pins2.convert_start_n = 1'b1;
    pins2.power_down_n = 1'b1;
    pins2.output_format_select = 1'b0;
    pins2.hst_d = 14'h0000;
    pins2.hst_oe_n = 14'h3fff;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      convert(i[0], i[1], i[2], codes[i % 4]);
    end
    shutdown_req = 1'b1;
    wait_on(3, 1'b1, "nap");
    cmp("sleep in nap", 14'h0, 14'(sleeping));
    shutdown_req = 1'b0;
    wait_on(3, 1'b0, "nap exit");
    shutdown_deep = 1'b1;
    shutdown_req = 1'b1;
    wait_on(4, 1'b1, "sleep");
    cmp("nap in sleep", 14'h0, 14'(napping));
    shutdown_req = 1'b0;
    wait_on(4, 1'b0, "sleep exit");
    convert(1'b0, 1'b0, 1'b0, 14'h0f0f);
    // second end: start and read without select, then restart attempts
    pins2.convert_start_n = 1'b0;
    pins2.rd_n = 1'b0;
    repeat (10) @(negedge clk);
    cmp("unselected", 14'h1, 14'(pins2.busy_n));
    cmp("read unselected", 14'h3fff, pins2.dev_oe_n);
    pins2.rd_n = 1'b1;
    pins2.convert_start_n = 1'b1;
    pins2.cs_n = 1'b0;
    repeat (4) @(negedge clk);
    pins2.convert_start_n = 1'b0;
    wait_on(5, 1'b0, "busy2 low");
    repeat (2) begin
      repeat (8) @(negedge clk);
      pins2.convert_start_n = 1'b1;
      repeat (8) @(negedge clk);
      pins2.convert_start_n = 1'b0;
    end
    wait_on(5, 1'b1, "busy2 high");
    cmp("no restart", 14'h1, 14'(waited + 32 <= 120));
    @(negedge clk);
    cmp("word2", 14'h1234, d2_result);
    pins2.rd_n = 1'b0;
    repeat (4) @(negedge clk);
    cmp("read2", 14'h1234, pins2.d);
    final_report();
  end
endmodule : sar_adc_control_interface_tb_top
